// [inc/hms_pkg.sv]
// Overview of operation
// - Axis conversion takes 43/59/91 us by range; temperature takes 43 us.
// - Fast mode starts the next cycle as soon as one completes.
// - Low-power mode starts a cycle only on a timer or external trigger.
// - Four-channel setup ends each cycle with the temperature conversion.
// - Three-channel setup skips temperature and keeps its stored result.
// - Three-channel setup ends the cycle right after the Z axis.
// - Angular setup skips Z and temperature and keeps both results.
// - Angular setup ends the cycle right after the Y axis.
// - Host-controlled mode converts only when the host triggers a cycle.
// - Temperature is enabled after reset; software may disable it.
package hms_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_HZ = 250000000;

  localparam int CONV_FULL_NS = 43000;
  localparam int CONV_SHORT_NS = 59000;
  localparam int CONV_XSHORT_NS = 91000;
  localparam int CONV_TEMP_NS = 43000;
  localparam int INT_DELAY_NS = 2500;
  localparam int INT_WIDTH_NS = 2500;
  localparam int LP_RATE_HZ = 97;

  localparam int CONV_FULL_CYC = CONV_FULL_NS / CLK_PERIOD_NS;
  localparam int CONV_SHORT_CYC = CONV_SHORT_NS / CLK_PERIOD_NS;
  localparam int CONV_XSHORT_CYC = CONV_XSHORT_NS / CLK_PERIOD_NS;
  localparam int CONV_TEMP_CYC = CONV_TEMP_NS / CLK_PERIOD_NS;
  localparam int INT_DELAY_CYC = INT_DELAY_NS / CLK_PERIOD_NS;
  localparam int INT_WIDTH_CYC = INT_WIDTH_NS / CLK_PERIOD_NS;
  localparam int TIMER_PERIOD_CYC = CLK_HZ / LP_RATE_HZ;

  localparam int RESULT_W = 12;
  localparam int INT_CNT_W = 16;
  localparam int FIFO_DEPTH_DEF = 8;

  typedef enum logic [1:0] {
    MODE_POWER_DOWN,
    MODE_LOW_POWER,
    MODE_FAST,
    MODE_HOST
  } hms_mode_t;

  typedef enum logic [1:0] {
    RANGE_FULL,
    RANGE_SHORT,
    RANGE_XSHORT
  } hms_range_t;

  typedef enum logic [1:0] {
    CFG_XYZT,
    CFG_XYZ,
    CFG_XY
  } hms_chans_t;

  typedef enum logic [1:0] {
    CH_X,
    CH_Y,
    CH_Z,
    CH_T
  } hms_chan_t;

  typedef struct packed {
    hms_mode_t mode;
    hms_range_t range;
    hms_chans_t chans;
    logic intEn;
  } hms_cfg_t;

  typedef struct packed {
    hms_chan_t chan;
    logic [RESULT_W-1:0] data;
  } hms_res_t;

  localparam hms_cfg_t CFG_RESET = '{
    mode: MODE_POWER_DOWN,
    range: RANGE_FULL,
    chans: CFG_XYZT,
    intEn: 1'b1
  };

endpackage

// [rtl/hms_toggle_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module hms_toggle_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic asyncIn,
  output logic level,
  output logic change
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;

  // Only sync2 and sync3 feed logic; sync1 may be metastable
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (ce) begin
      sync1_reg <= asyncIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign level = sync2_reg;
  assign change = sync2_reg ^ sync3_reg;

endmodule
`default_nettype wire

// [rtl/hms_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module hms_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrValid,
  input wire logic [WIDTH-1:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [WIDTH-1:0] rdData,
  input wire logic rdReady
);

  // DEPTH must be a power of two; pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doWrite;
  logic doLoad;

  assign wrReady = count_reg != (AW+1)'(DEPTH);
  assign doWrite = wrValid && wrReady;
  assign doLoad = (count_reg != '0) && (!rdValid || rdReady);

  always_ff @(posedge clk) begin
    if (ce && doWrite) begin
      mem[wrPtr_reg] <= wrData;
    end
  end

  // Output stage is a register so read data never come from a mux
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      rdValid <= 1'b0;
      rdData <= '0;
    end else if (ce) begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (doLoad) begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
        rdData <= mem[rdPtr_reg];
        rdValid <= 1'b1;
      end else if (rdReady) begin
        rdValid <= 1'b0;
      end
      count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doLoad);
    end
  end

endmodule
`default_nettype wire

// [rtl/hms_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module hms_sequencer
  import hms_pkg::*;
#(
  parameter int unsigned CONV_FULL = CONV_FULL_CYC,
  parameter int unsigned CONV_SHORT = CONV_SHORT_CYC,
  parameter int unsigned CONV_XSHORT = CONV_XSHORT_CYC,
  parameter int unsigned CONV_TEMP = CONV_TEMP_CYC,
  parameter int unsigned TIMER_PERIOD = TIMER_PERIOD_CYC,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic hostTrig,
  input wire logic extTrigPin,
  input wire logic cfgWrite,
  input wire hms_cfg_t cfgIn,
  input wire logic [RESULT_W-1:0] adcResult,
  input wire logic rdReady,
  output hms_res_t rdData,
  output logic rdValid,
  output hms_cfg_t cfgState,
  output logic cycleBusy,
  output hms_chan_t convChannel,
  output logic [RESULT_W-1:0] xResult,
  output logic [RESULT_W-1:0] yResult,
  output logic [RESULT_W-1:0] zResult,
  output logic [RESULT_W-1:0] tResult,
  output logic intN
);

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} hms_state_t;
  typedef enum logic [1:0] {INT_IDLE, INT_DELAY, INT_PULSE} hms_int_t;

  hms_state_t state_reg;
  hms_state_t state_next;
  hms_chan_t chan_reg;
  hms_chan_t chan_next;
  hms_int_t intPhase_reg;
  hms_int_t intPhase_next;
  hms_cfg_t cfg_reg;
  hms_range_t cycRange_reg;
  hms_chans_t cycChans_reg;
  hms_chan_t lastChan;
  hms_res_t fifoIn;
  logic hostTog_reg;
  logic pending_reg;
  logic [31:0] timerCnt_reg;
  logic [31:0] convCnt_reg;
  logic [31:0] axisLen;
  logic [31:0] convLen;
  logic [INT_CNT_W-1:0] intCnt_reg;
  logic [RESULT_W-1:0] sample_reg;
  logic hostTrigPulse;
  logic extLevel;
  logic extChange;
  logic extRise;
  logic timerHit;
  logic trigReq;
  logic fastMode;
  logic startCycle;
  logic convEnd;
  logic fifoWrReady;
  logic storeOk;
  logic cycleDone;
  logic loadCycCfg;
  logic intDelayEnd;
  logic intWidthEnd;

  // Link side: a host access flips a toggle, so no event is lost
  // however the two clocks line up
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      hostTog_reg <= 1'b0;
    end else if (hostTrig) begin
      hostTog_reg <= ~hostTog_reg;
    end
  end

  hms_toggle_sync hostSync (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn(hostTog_reg),
    .level(),
    .change(hostTrigPulse)
  );

  hms_toggle_sync pinSync (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn(extTrigPin),
    .level(extLevel),
    .change(extChange)
  );

  assign extRise = extLevel && extChange;
  assign fastMode = cfg_reg.mode == MODE_FAST;
  assign timerHit = (cfg_reg.mode == MODE_LOW_POWER) &&
                    (timerCnt_reg == TIMER_PERIOD - 1);

  // Low power answers timer and pin; host mode only its own access
  assign trigReq = ((cfg_reg.mode == MODE_LOW_POWER) &&
                    (timerHit || extRise)) ||
                   ((cfg_reg.mode == MODE_HOST) && hostTrigPulse);

  assign startCycle = (state_reg == ST_IDLE) &&
                      (fastMode ||
                       (pending_reg &&
                        cfg_reg.mode != MODE_POWER_DOWN));

  assign axisLen = (cycRange_reg == RANGE_SHORT) ? 32'(CONV_SHORT) :
                   (cycRange_reg == RANGE_XSHORT) ? 32'(CONV_XSHORT) :
                   32'(CONV_FULL);
  assign convLen = (chan_reg == CH_T) ? 32'(CONV_TEMP) : axisLen;
  assign convEnd = (state_reg == ST_CONV) && (convCnt_reg == convLen - 1);

  // Where the cycle stops is fixed by the setup latched at its start
  assign lastChan = (cycChans_reg == CFG_XY) ? CH_Y :
                    (cycChans_reg == CFG_XYZ) ? CH_Z :
                    CH_T;

  assign storeOk = (state_reg == ST_STORE) && fifoWrReady;
  assign cycleDone = ce && storeOk && (chan_reg == lastChan);
  assign loadCycCfg = ce && ((state_reg == ST_IDLE && startCycle) ||
                             (cycleDone && fastMode));

  assign fifoIn = '{chan: chan_reg, data: sample_reg};

  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (startCycle) begin
          state_next = ST_CONV;
          chan_next = CH_X;
        end
      end
      ST_CONV: begin
        if (convEnd) begin
          state_next = ST_STORE;
        end
      end
      ST_STORE: begin
        // A full FIFO holds the sequencer here until the host drains
        if (fifoWrReady) begin
          if (chan_reg == lastChan) begin
            state_next = fastMode ? ST_CONV : ST_IDLE;
            chan_next = CH_X;
          end else begin
            state_next = ST_CONV;
            chan_next = hms_chan_t'(2'(chan_reg + 2'd1));
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        chan_next = CH_X;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_reg <= CFG_RESET;
    end else if (ce && cfgWrite) begin
      cfg_reg <= cfgIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      chan_reg <= CH_X;
      cycleBusy <= 1'b0;
      convChannel <= CH_X;
    end else if (ce) begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      cycleBusy <= state_next != ST_IDLE;
      convChannel <= chan_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cycRange_reg <= RANGE_FULL;
      cycChans_reg <= CFG_XYZT;
    end else if (loadCycCfg) begin
      cycRange_reg <= cfg_reg.range;
      cycChans_reg <= cfg_reg.chans;
    end
  end

  // Trigger arriving as a cycle starts wins, queueing one more cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending_reg <= 1'b0;
    end else if (ce) begin
      if (trigReq) begin
        pending_reg <= 1'b1;
      end else if (state_reg == ST_IDLE && startCycle) begin
        pending_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timerCnt_reg <= '0;
    end else if (ce) begin
      if (cfg_reg.mode != MODE_LOW_POWER || timerHit) begin
        timerCnt_reg <= '0;
      end else begin
        timerCnt_reg <= timerCnt_reg + 32'd1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      convCnt_reg <= '0;
      sample_reg <= '0;
    end else if (ce) begin
      if (state_reg != ST_CONV || convEnd) begin
        convCnt_reg <= '0;
      end else begin
        convCnt_reg <= convCnt_reg + 32'd1;
      end
      if (convEnd) begin
        sample_reg <= adcResult;
      end
    end
  end

  // Only the channel just converted updates; the others keep old data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xResult <= '0;
      yResult <= '0;
      zResult <= '0;
      tResult <= '0;
    end else if (ce && storeOk) begin
      unique case (chan_reg)
        CH_X: xResult <= sample_reg;
        CH_Y: yResult <= sample_reg;
        CH_Z: zResult <= sample_reg;
        CH_T: tResult <= sample_reg;
      endcase
    end
  end

  hms_fifo #(
    .WIDTH($bits(hms_res_t)),
    .DEPTH(FIFO_DEPTH)
  ) resultFifo (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wrValid(state_reg == ST_STORE),
    .wrData(fifoIn),
    .wrReady(fifoWrReady),
    .rdValid(rdValid),
    .rdData(rdData),
    .rdReady(rdReady)
  );

  assign intDelayEnd = intCnt_reg == INT_CNT_W'(INT_DELAY_CYC - 1);
  assign intWidthEnd = intCnt_reg == INT_CNT_W'(INT_WIDTH_CYC - 1);

  // A cycle ending while a pulse is under way gets no second pulse
  always_comb begin
    intPhase_next = intPhase_reg;
    unique case (intPhase_reg)
      INT_IDLE: begin
        if (cycleDone && cfg_reg.intEn) begin
          intPhase_next = INT_DELAY;
        end
      end
      INT_DELAY: begin
        if (intDelayEnd) begin
          intPhase_next = INT_PULSE;
        end
      end
      INT_PULSE: begin
        if (intWidthEnd) begin
          intPhase_next = INT_IDLE;
        end
      end
      default: intPhase_next = INT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intPhase_reg <= INT_IDLE;
      intCnt_reg <= '0;
      intN <= 1'b1;
    end else if (ce) begin
      intPhase_reg <= intPhase_next;
      intN <= intPhase_next != INT_PULSE;
      if (intPhase_next != intPhase_reg) begin
        intCnt_reg <= '0;
      end else begin
        intCnt_reg <= intCnt_reg + INT_CNT_W'(1);
      end
    end
  end

  assign cfgState = cfg_reg;

  a_conv_length: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_STORE && $past(state_reg) == ST_CONV) |->
    $past(convCnt_reg) == $past(convLen) - 1)
    else $error("conversion length wrong");

  a_axis_full: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_CONV && chan_reg != CH_T &&
     cycRange_reg == RANGE_FULL) |-> convLen == CONV_FULL)
    else $error("full range time wrong");

  a_fast_restart: assert property (@(posedge ref_clk) disable iff (rst)
    (cycleDone && fastMode) |=>
    state_reg == ST_CONV && chan_reg == CH_X)
    else $error("fast mode did not restart");

  a_trig_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_IDLE && !fastMode) ##1 state_reg == ST_CONV |->
    $past(pending_reg))
    else $error("cycle started without trigger");

  a_host_trig: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && cfg_reg.mode == MODE_HOST && hostTrigPulse) |=>
    pending_reg)
    else $error("host trigger lost");

  a_end_four: assert property (@(posedge ref_clk) disable iff (rst)
    (cycleDone && cycChans_reg == CFG_XYZT) |-> chan_reg == CH_T)
    else $error("four channel cycle end wrong");

  a_skip_temp: assert property (@(posedge ref_clk) disable iff (rst)
    ((cycChans_reg == CFG_XYZ || cycChans_reg == CFG_XY) &&
     state_reg != ST_IDLE) |-> chan_reg != CH_T)
    else $error("temperature converted");

  a_end_three: assert property (@(posedge ref_clk) disable iff (rst)
    (cycleDone && cycChans_reg == CFG_XYZ) |-> chan_reg == CH_Z)
    else $error("three channel cycle end wrong");

  a_keep_z: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(zResult) |->
    $past(storeOk && chan_reg == CH_Z && cycChans_reg != CFG_XY))
    else $error("Z result changed");

  a_end_two: assert property (@(posedge ref_clk) disable iff (rst)
    (cycleDone && cycChans_reg == CFG_XY) |-> chan_reg == CH_Y)
    else $error("angular cycle end wrong");

  a_temp_reset: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> cfg_reg.chans == CFG_XYZT)
    else $error("temperature not enabled after reset");

  a_chan_order: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && storeOk && chan_reg != lastChan) |=>
    state_reg == ST_CONV &&
    chan_reg == hms_chan_t'(2'($past(chan_reg) + 2'd1)))
    else $error("channel order wrong");

  a_int_delay: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(intN) |-> $past(intPhase_reg) == INT_DELAY &&
    $past(intDelayEnd))
    else $error("interrupt delay wrong");

  a_int_width: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(intN) |-> $past(intWidthEnd) &&
    $past(intPhase_reg) == INT_PULSE)
    else $error("interrupt width wrong");

endmodule
`default_nettype wire

// [testbench/hms_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module hms_host_model (
  input wire logic ref_clk,
  input wire logic linkClk,
  input wire logic stall,
  output logic hostTrig,
  output logic rdReady
);
  logic [1:0] k = 2'h0;
  initial hostTrig = 1'b0;
  initial rdReady = 1'b0;
  // One linkClk-wide pulse stands for one trigger access
  task automatic trig();
    @(posedge linkClk);
    hostTrig <= 1'b1;
    @(posedge linkClk);
    hostTrig <= 1'b0;
  endtask
  // Mix of prompt and slow reads, so the FIFO sees back-pressure
  always @(negedge ref_clk) begin
    k <= k + 2'h1;
    rdReady <= !stall && (k != 2'h0);
  end
endmodule
`default_nettype wire

// [testbench/test_hms_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module test_hms_sequencer import hms_pkg::*; ();
  localparam int CF = 20;
  localparam int CS = 30;
  localparam int CX = 40;
  localparam int CT = 24;
  logic ref_clk = 1'b0;
  logic linkClk = 1'b0;
  logic rst = 1'b1;
  logic linkRst = 1'b1;
  logic extTrigPin = 1'b0;
  logic cfgWrite = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  logic hostTrig, rdReady, rdValid, cycleBusy, intN;
  hms_cfg_t cfgIn = CFG_RESET;
  hms_cfg_t cfgState;
  hms_res_t rdData;
  hms_chan_t convChannel;
  logic [11:0] xResult, yResult, zResult, tResult, adcResult, zo, to;
  logic [11:0] adcVal [4] = '{12'h000, 12'h000, 12'h000, 12'h000};
  logic [31:0] rs = 32'h18;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int idx = 0;
  int nch = 4;
  int n;
  int lens [3] = '{CF, CS, CX};
  always #2 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #15 linkClk = ~linkClk;
  end
  // ADC model answers with the value of the channel being converted
  assign adcResult = adcVal[convChannel];
  hms_sequencer #(.CONV_FULL(CF), .CONV_SHORT(CS), .CONV_XSHORT(CX),
    .CONV_TEMP(CT), .TIMER_PERIOD(200), .FIFO_DEPTH(8)) DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .linkClk(linkClk),
    .linkRst(linkRst), .hostTrig(hostTrig), .extTrigPin(extTrigPin),
    .cfgWrite(cfgWrite), .cfgIn(cfgIn), .adcResult(adcResult),
    .rdReady(rdReady), .rdData(rdData), .rdValid(rdValid),
    .cfgState(cfgState), .cycleBusy(cycleBusy), .convChannel(convChannel),
    .xResult(xResult), .yResult(yResult), .zResult(zResult),
    .tResult(tResult), .intN(intN));
  hms_host_model host (.ref_clk(ref_clk), .linkClk(linkClk), .stall(stall),
    .hostTrig(hostTrig), .rdReady(rdReady));
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic newvals();
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      v = xs();
      adcVal[i] = v[11:0];
    end
    zo = zResult;
    to = tResult;
  endtask
  task automatic setcfg(input hms_mode_t m, input hms_range_t r,
                        input hms_chans_t c, input logic ie);
    @(negedge ref_clk);
    cfgIn = '{m, r, c, ie};
    cfgWrite = 1'b1;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
    nch = (c == CFG_XY) ? 2 : (c == CFG_XYZ) ? 3 : 4;
    chk("cfgState", cfgIn, cfgState);
  endtask
  // Busy length: every channel converts, then spends one store cycle
  task automatic cycle(input int len);
    int e;
    e = (nch > 3 ? CT + 1 : 0) + (nch > 2 ? 3 : 2) * (len + 1);
    n = 0;
    while (cycleBusy !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk("cycle start", 1, n < 400);
    n = 0;
    while (cycleBusy === 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("cycle length", 1, n >= e && n <= e + 3);
    n = 0;
    while ((rdValid === 1'b1 || n < 3) && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk("x stored", adcVal[0], xResult);
    chk("y stored", adcVal[1], yResult);
    chk("z stored", nch > 2 ? adcVal[2] : zo, zResult);
    chk("t stored", nch > 3 ? adcVal[3] : to, tResult);
    chk("word phase", 0, idx);
  endtask
  task automatic quiet(input int k);
    int b;
    b = 0;
    repeat (k) begin
      @(negedge ref_clk);
      b += (cycleBusy !== 1'b0 || intN !== 1'b1);
    end
    chk("idle", 0, b);
  endtask
  // A frozen block pops nothing, so no word is counted while ce is low
  always @(posedge ref_clk) begin
    cyc++;
    if (ce === 1'b1 && rdValid === 1'b1 && rdReady === 1'b1) begin
      chk("word chan", idx, rdData.chan);
      chk("word data", adcVal[idx], rdData.data);
      idx = (idx + 1) % nch;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    linkRst = 1'b0;
    chk("reset cfg", CFG_RESET, cfgState);
    chk("reset int", 1, intN);
    host.trig();
    extTrigPin = 1'b1;
    quiet(100);
    extTrigPin = 1'b0;
    setcfg(MODE_HOST, RANGE_FULL, CFG_XYZT, 1'b1);
    quiet(300);
    newvals();
    host.trig();
    cycle(CF);
    n = 0;
    while (intN !== 1'b0 && n < 700) begin
      @(negedge ref_clk);
      n++;
    end
    chk("int delay", 1, n >= INT_DELAY_CYC - 12 && n <= INT_DELAY_CYC);
    n = 0;
    while (intN === 1'b0 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("int width", INT_WIDTH_CYC, n);
    for (int r = 0; r < 3; r++) begin
      for (int c = 1; c < 3; c++) begin
        setcfg(MODE_HOST, hms_range_t'(r), hms_chans_t'(c), 1'b0);
        newvals();
        host.trig();
        cycle(lens[r]);
      end
    end
    quiet(1400);
    setcfg(MODE_FAST, RANGE_FULL, CFG_XY, 1'b1);
    stall = 1'b1;
    repeat (600) @(negedge ref_clk);
    stall = 1'b0;
    n = 0;
    repeat (300) begin
      @(negedge ref_clk);
      n += (cycleBusy === 1'b1);
    end
    chk("fast restart", 1, n >= 295);
    setcfg(MODE_LOW_POWER, RANGE_FULL, CFG_XY, 1'b0);
    // The fast cycle under way must finish before the timer takes over
    n = 0;
    while (cycleBusy === 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk("fast stop", 1, n < 100);
    cycle(CF);
    extTrigPin = 1'b1;
    n = 0;
    while (cycleBusy !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk("pin start", 1, n < 8);
    extTrigPin = 1'b0;
    cycle(CF);
    ce = 1'b0;
    cfgIn.mode = MODE_HOST;
    cfgWrite = 1'b1;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
    chk("ce freeze", MODE_LOW_POWER, cfgState.mode);
    end_of_test();
  end
endmodule
`default_nettype wire
